// >>> core/sensor_port_regs.svh
// Constants of the dual-select sensor serial port.
// Assumes inclusion by bare name from the core sources.
`ifndef SENSOR_PORT_REGS_SVH
`define SENSOR_PORT_REGS_SVH

// Accelerometer control word
`define CTRL_RESET        8'h04
`define CTRL_IGNORED_BIT  7
`define CTRL_AXIS_BIT     3
`define CTRL_PWR_BIT      0
`define CTRL_WIDTH        8

// Positions in the 16-clock frame, counted in rising edges already seen
`define FRAME_LAST        4'hF
`define CTRL_LAST_POS     4'h7
`define SAMPLE_POS        4'h1
`define TEMP_LOAD_POS     4'h0
`define ACC_LEAD_ZEROS    4'h4
`define ACC_MSB_POS       4'hF
`define TEMP_LAST_POS     4'hA

// Acceleration code
`define CODE_WIDTH        12
`define CODE_ZERO_G       12'h800
`define CODE_MAX          12'hFFF
`define SELF_TEST_SHIFT   12'h0CD

// Temperature
`define TEMP_WIDTH        10
`define TEMP_RESET        10'h000
`define TEMP_PERIOD_US    350
`define TEMP_CONV_US      25
`define MCLK_MHZ          100

`endif

// >>> core/sensor_port_pkg.sv
// Types shared by the sensor serial port sources.
// Assumes the constants header is compiled alongside.
package sensor_port_pkg;

  typedef enum logic [1:0] {
    FRAME_NONE,
    FRAME_ACCEL,
    FRAME_TEMP
  } frame_t;

  typedef enum logic {
    TEMP_WAIT,
    TEMP_CONVERT
  } temp_state_t;

endpackage

// >>> core/level_sync2.sv
// Two-flop synchroniser for quasi-static levels.
// Assumes each bit changes far slower than the destination clock.
`timescale 1ns/100ps
module level_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> core/temp_autoconvert.sv
// Temperature autoconversion timer with read lockout.
// Assumes read_busy is already synchronised to clk.
`timescale 1ns/100ps
`include "sensor_port_regs.svh"
module temp_autoconvert #(
  parameter int PERIOD_CYCLES = `TEMP_PERIOD_US * `MCLK_MHZ,
  parameter int CONV_CYCLES   = `TEMP_CONV_US * `MCLK_MHZ
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   read_busy,
  input  wire logic [`TEMP_WIDTH-1:0] temp_code,
  output logic      [`TEMP_WIDTH-1:0] temp_word
);

  localparam int TW = $clog2(PERIOD_CYCLES + 1);

  sensor_port_pkg::temp_state_t state;
  logic [TW-1:0]                timer;
  logic                         lockout;
  logic                         busy_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= read_busy;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= sensor_port_pkg::TEMP_WAIT;
      timer     <= '0;
      lockout   <= 1'b0;
      temp_word <= `TEMP_RESET;
    end else begin
      unique case (state)
        sensor_port_pkg::TEMP_WAIT: begin
          if (busy_q && !read_busy) begin
            timer <= '0; // Oscillator restarts when a read ends
          end else if (timer == TW'(PERIOD_CYCLES - 1)) begin
            timer   <= '0;
            state   <= sensor_port_pkg::TEMP_CONVERT;
            lockout <= read_busy; // Cleared only at a conversion start
          end else begin
            timer <= timer + 1'b1;
          end
        end
        sensor_port_pkg::TEMP_CONVERT: begin
          if (read_busy) begin
            lockout <= 1'b1;
          end
          if (timer == TW'(CONV_CYCLES - 1)) begin
            timer <= '0;
            state <= sensor_port_pkg::TEMP_WAIT;
            if (!lockout && !read_busy) begin
              temp_word <= temp_code;
            end
          end else begin
            timer <= timer + 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// >>> core/dual_select_sensor_serial_port.sv
// Serial slave port of a dual-axis accelerometer with temperature sensor.
// Assumes the host idles sclk high between frames and frames on whole
// 16-clock groups; sensor codes arrive as levels on mclk.
`timescale 1ns/100ps
`include "sensor_port_regs.svh"
module dual_select_sensor_serial_port #(
  parameter int TEMP_PERIOD_CYCLES = `TEMP_PERIOD_US * `MCLK_MHZ,
  parameter int TEMP_CONV_CYCLES   = `TEMP_CONV_US * `MCLK_MHZ
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   sclk,
  input  wire logic                   accel_select_n,
  input  wire logic                   temp_select_n,
  input  wire logic                   din,
  input  wire logic                   self_test_in,
  input  wire logic [`CODE_WIDTH-1:0] accel_x_code,
  input  wire logic [`CODE_WIDTH-1:0] accel_y_code,
  input  wire logic [`TEMP_WIDTH-1:0] temp_code,
  output logic                        dout,
  output logic                        dout_oe,
  output logic                        shutdown,
  output logic                        axis_is_y,
  output logic                        select_conflict,
  output logic                        temp_write_fault
);

  // Saturating self-test offset on an offset-binary code
  function automatic logic [`CODE_WIDTH-1:0] apply_self_test(
    input logic [`CODE_WIDTH-1:0] code,
    input logic                   st
  );
    logic [`CODE_WIDTH:0] sum;
    sum = {1'b0, code} + {1'b0, `SELF_TEST_SHIFT};
    if (!st) begin
      apply_self_test = code;
    end else if (sum[`CODE_WIDTH]) begin
      apply_self_test = `CODE_MAX;
    end else begin
      apply_self_test = sum[`CODE_WIDTH-1:0];
    end
  endfunction

  // Bit of a right-aligned word sent MSB first, ending at frame position last
  function automatic logic word_bit(
    input logic [15:0] word,
    input logic [3:0]  last,
    input logic [3:0]  pos
  );
    logic [3:0] idx;
    idx = last - pos;
    word_bit = word[idx];
  endfunction

  // ---------------- Link domain (sclk) ----------------

  // Selects frame the link; idle holds the frame logic in reset, which is
  // why the counter needs no clock edge outside a frame.
  logic link_idle;
  logic link_rst;
  assign link_idle = accel_select_n & temp_select_n;
  assign link_rst  = sys_rst | link_idle;

  sensor_port_pkg::frame_t frame_kind;
  always_comb begin
    if (!accel_select_n) begin
      frame_kind = sensor_port_pkg::FRAME_ACCEL;
    end else if (!temp_select_n) begin
      frame_kind = sensor_port_pkg::FRAME_TEMP;
    end else begin
      frame_kind = sensor_port_pkg::FRAME_NONE;
    end
  end

  logic [3:0] rise_count;
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rise_count <= 4'h0;
    end else begin
      rise_count <= rise_count + 4'h1;
    end
  end

  // Control word arrives MSB first on the first eight rising edges
  logic [`CTRL_WIDTH-2:0] ctrl_shift;
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      ctrl_shift <= '0;
    end else if (rise_count < `CTRL_LAST_POS) begin
      ctrl_shift <= {ctrl_shift[`CTRL_WIDTH-3:0], din};
    end
  end

  logic [`CTRL_WIDTH-1:0] ctrl_word;
  logic                   ctrl_commit;
  logic [`CTRL_WIDTH-1:0] next_ctrl;
  assign ctrl_commit = (frame_kind == sensor_port_pkg::FRAME_ACCEL) && (rise_count == `CTRL_LAST_POS);
  assign next_ctrl   = {ctrl_shift, din};

  // Only power-up resets it, to 8'h04; shutdown leaves it alone
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_word <= `CTRL_RESET;
    end else if (ctrl_commit) begin
      ctrl_word <= next_ctrl;
    end
  end

  // A literal cannot be bit-selected, so the reset word is named first
  localparam logic [`CTRL_WIDTH-1:0] CTRL_INIT = `CTRL_RESET;

  logic pwr_down;
  logic wake_pending;
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_down     <= CTRL_INIT[`CTRL_PWR_BIT];
      wake_pending <= 1'b0;
    end else if (ctrl_commit && next_ctrl[`CTRL_PWR_BIT]) begin
      pwr_down     <= 1'b1;
      wake_pending <= 1'b0;
    end else if (ctrl_commit && pwr_down) begin
      wake_pending <= 1'b1;
    end else if (wake_pending && frame_kind == sensor_port_pkg::FRAME_ACCEL && rise_count == `FRAME_LAST) begin
      pwr_down     <= 1'b0;
      wake_pending <= 1'b0;
    end
  end

  // Word sampled from mclk registers that are frozen for the frame
  logic [`CODE_WIDTH-1:0] x_word;
  logic [`CODE_WIDTH-1:0] y_word;
  logic [`TEMP_WIDTH-1:0] temp_word;
  logic [`CODE_WIDTH-1:0] acc_sample;
  logic [`TEMP_WIDTH-1:0] temp_sample;

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_sample <= `CODE_ZERO_G;
    end else if (frame_kind == sensor_port_pkg::FRAME_ACCEL && rise_count == `SAMPLE_POS && !pwr_down) begin
      // Stored axis, not the one arriving in this frame
      acc_sample <= ctrl_word[`CTRL_AXIS_BIT] ? y_word : x_word;
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_sample <= `TEMP_RESET;
    end else if (frame_kind == sensor_port_pkg::FRAME_TEMP && rise_count == `TEMP_LOAD_POS) begin
      temp_sample <= temp_word;
    end
  end

  // Concurrent temperature write: every bit is expected low
  logic temp_wr_bad;
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_wr_bad <= 1'b0;
    end else if (frame_kind == sensor_port_pkg::FRAME_TEMP && rise_count == `TEMP_LOAD_POS) begin
      temp_wr_bad <= din;
    end else if (frame_kind == sensor_port_pkg::FRAME_TEMP && din) begin
      temp_wr_bad <= 1'b1;
    end
  end

  logic next_dout;
  always_comb begin
    next_dout = 1'b0;
    unique case (frame_kind)
      sensor_port_pkg::FRAME_ACCEL: begin
        if (rise_count >= `ACC_LEAD_ZEROS) begin
          next_dout = word_bit({4'h0, acc_sample}, `ACC_MSB_POS, rise_count);
        end
      end
      sensor_port_pkg::FRAME_TEMP: begin
        if (rise_count == `TEMP_LOAD_POS) begin
          next_dout = 1'b0;
        end else if (rise_count <= `TEMP_LAST_POS) begin
          next_dout = word_bit({6'h00, temp_sample}, `TEMP_LAST_POS, rise_count);
        end else begin
          next_dout = dout;
        end
      end
      sensor_port_pkg::FRAME_NONE: begin
        next_dout = 1'b0;
      end
    endcase
  end

  // Both selects high (or sys_rst) clears these at once, with no sclk edge needed
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout    <= next_dout;
      dout_oe <= 1'b1;
    end
  end

  // ---------------- Core domain (mclk) ----------------

  logic [4:0] sync_in;
  logic [4:0] sync_out;
  logic       accel_busy;
  logic       temp_busy;
  logic       pwr_sync;
  logic       axis_sync;
  logic       st_sync;

  // All quasi-static: selects, stored mode bits and the self-test pin
  assign sync_in = {~accel_select_n, ~temp_select_n, pwr_down, ctrl_word[`CTRL_AXIS_BIT], self_test_in};

  level_sync2 #(
    .WIDTH (5)
  ) u_sync (
    .clk      (mclk),
    .rst      (sys_rst),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign accel_busy = sync_out[4];
  assign temp_busy  = sync_out[3];
  assign pwr_sync   = sync_out[2];
  assign axis_sync  = sync_out[1];
  assign st_sync    = sync_out[0];

  // Published words change only between accelerometer frames, so the
  // link reads a settled value; shutdown holds the last conversion.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      x_word <= `CODE_ZERO_G;
      y_word <= `CODE_ZERO_G;
    end else if (!accel_busy && !pwr_sync) begin
      x_word <= apply_self_test(accel_x_code, st_sync);
      y_word <= apply_self_test(accel_y_code, st_sync);
    end
  end

  temp_autoconvert #(
    .PERIOD_CYCLES (TEMP_PERIOD_CYCLES),
    .CONV_CYCLES   (TEMP_CONV_CYCLES)
  ) u_temp (
    .clk       (mclk),
    .rst       (sys_rst),
    .read_busy (temp_busy),
    .temp_code (temp_code),
    .temp_word (temp_word)
  );

  logic wr_bad_meta;
  logic wr_bad_sync;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_bad_meta <= 1'b0;
      wr_bad_sync <= 1'b0;
    end else begin
      wr_bad_meta <= temp_wr_bad;
      wr_bad_sync <= wr_bad_meta;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdown         <= 1'b0;
      axis_is_y        <= 1'b0;
      select_conflict  <= 1'b0;
      temp_write_fault <= 1'b0;
    end else begin
      shutdown         <= pwr_sync;
      axis_is_y        <= axis_sync;
      select_conflict  <= accel_busy & temp_busy;
      temp_write_fault <= wr_bad_sync & ~temp_busy;
    end
  end

endmodule

// >>> test/sensor_port_asserts.sv
// Pin-level checker for the sensor serial port.
// Bound to the port top; sees its ports only.
`timescale 1ns/100ps
module sensor_port_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic accel_select_n,
  input wire logic temp_select_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic shutdown,
  input wire logic axis_is_y,
  input wire logic select_conflict
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] ctrl;
  wire        idle = accel_select_n & temp_select_n;
  wire        clr  = sys_rst | idle;
  wire        tfr  = !temp_select_n & accel_select_n;
  // Rising edges seen in the frame, wraps every 16 edges
  always_ff @(posedge sclk or posedge clr) begin
    if (clr)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
  end
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      sh   <= 8'h00;
      ctrl <= 8'h04;
    end else if (!accel_select_n) begin
      sh <= {sh[6:0], din};
      if (cnt == 4'h7)
        ctrl <= {sh[6:0], din};
    end
  end
  sequence s_both_low;
    !accel_select_n && !temp_select_n;
  endsequence
  sequence s_pm_set;
    $rose(ctrl[0]);
  endsequence
  a_release_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    idle |-> !dout_oe && !dout) else $error("output driven while idle");
  a_conflict_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    s_both_low ##1 s_both_low ##1 s_both_low |-> ##[0:4] select_conflict) else $error("conflict not flagged");
  a_accel_zeros: assert property (@(posedge sclk) disable iff (sys_rst)
    (!accel_select_n && cnt < 4'h4) |-> dout_oe && !dout) else $error("lead zeros wrong");
  a_dout_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(sclk) |-> $stable(dout)) else $error("dout moved on rising edge");
  a_temp_lead: assert property (@(posedge sclk) disable iff (sys_rst)
    (tfr && cnt == 4'h0) |-> dout_oe && !dout) else $error("temp lead bit wrong");
  a_temp_hold: assert property (@(posedge sclk) disable iff (sys_rst)
    (tfr && cnt > 4'hB) |-> $stable(dout) && dout_oe) else $error("temp last bit not held");
  a_power_down: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pm_set |-> ##[1:8] shutdown) else $error("shutdown not entered");
  a_axis_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(ctrl[3]) |-> ##[1:8] axis_is_y == ctrl[3]) else $error("axis bit not stored");
  a_wake_cleared: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(shutdown) |-> !ctrl[0]) else $error("woke with power-down set");
endmodule
bind dual_select_sensor_serial_port sensor_port_asserts u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .accel_select_n(accel_select_n),
  .temp_select_n(temp_select_n), .din(din), .dout(dout), .dout_oe(dout_oe),
  .shutdown(shutdown), .axis_is_y(axis_is_y), .select_conflict(select_conflict));

// >>> test/spi_host_model.sv
// Host serial master for the sensor port.
// Assumes its tasks are called one at a time.
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      sclk,
  output logic      accel_select_n,
  output logic      temp_select_n,
  output logic      din
);
  logic last;
  // Released line shows the inverse, never a stale bit
  wire  line = dout_oe ? dout : ~last;
  initial begin
    sclk = 1'b1;
    accel_select_n = 1'b1;
    temp_select_n = 1'b1;
    din = 1'b0;
    last = 1'b0;
  end
  task frame(input logic acc, input logic [7:0] word, input int n, output logic [15:0] rx);
    int i;
    if (acc)
      accel_select_n = 1'b0;
    else
      temp_select_n = 1'b0;
    // Odd lead keeps serial edges off the core clock edges
    #17;
    // Far above the advised sample rate: no filter here needs recovery time
    for (i = 0; i < 16 * n; i++) begin
      sclk = 1'b0;
      din = (i % 16 < 8) ? word[7 - i % 16] : 1'b0;
      #15;
      sclk = 1'b1;
      rx = {rx[14:0], line};
      last = line;
      #15;
    end
    accel_select_n = 1'b1;
    temp_select_n = 1'b1;
    din = 1'b0;
    #30;
  endtask
  // Deliberate overlap of both selects
  task both_low;
    accel_select_n = 1'b0;
    temp_select_n = 1'b0;
    #300;
    accel_select_n = 1'b1;
    temp_select_n = 1'b1;
    #30;
  endtask
endmodule

// >>> test/dual_select_sensor_serial_port_tb.sv
// Self-checking bench for the sensor serial port.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/100ps
module dual_select_sensor_serial_port_tb;
  typedef struct packed {
    logic        acc;
    logic [7:0]  word;
    logic [11:0] x;
    logic [11:0] y;
    logic        st;
    logic [9:0]  t;
    logic [15:0] exp;
  } row_t;
  logic        mclk, sys_rst, sclk, accel_select_n, temp_select_n, din, self_test_in;
  logic [11:0] accel_x_code, accel_y_code;
  logic [9:0]  temp_code;
  logic        dout, dout_oe, shutdown, axis_is_y, select_conflict, temp_write_fault;
  logic [15:0] rx;
  int          bad_count = 0;
  int          cmp_count = 0;
  row_t        rows [7] = '{
    '{1'b1, 8'h04, 12'h800, 12'h123, 1'b0, 10'h000, 16'h0800},
    '{1'b1, 8'h0C, 12'h800, 12'hD00, 1'b0, 10'h000, 16'h0D00},
    '{1'b1, 8'h84, 12'h300, 12'h123, 1'b0, 10'h000, 16'h0300},
    '{1'b1, 8'h0C, 12'h800, 12'hF80, 1'b1, 10'h000, 16'h0FFF},
    '{1'b1, 8'h04, 12'h800, 12'h123, 1'b1, 10'h000, 16'h08CD},
    '{1'b0, 8'h00, 12'h800, 12'h800, 1'b0, 10'h3FF, 16'h7FFF},
    '{1'b0, 8'h00, 12'h800, 12'h800, 1'b0, 10'h064, 16'h0C80}};
  dual_select_sensor_serial_port #(.TEMP_PERIOD_CYCLES(200), .TEMP_CONV_CYCLES(20)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .accel_select_n(accel_select_n),
    .temp_select_n(temp_select_n), .din(din), .self_test_in(self_test_in),
    .accel_x_code(accel_x_code), .accel_y_code(accel_y_code), .temp_code(temp_code),
    .dout(dout), .dout_oe(dout_oe), .shutdown(shutdown), .axis_is_y(axis_is_y),
    .select_conflict(select_conflict), .temp_write_fault(temp_write_fault));
  spi_host_model host (.dout(dout), .dout_oe(dout_oe), .sclk(sclk), .accel_select_n(accel_select_n),
    .temp_select_n(temp_select_n), .din(din));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = shutdown;
      1: pick = axis_is_y;
      2: pick = select_conflict;
      default: pick = temp_write_fault;
    endcase
  endfunction
  task wait_sig(input int w, input logic want);
    int n;
    n = 0;
    while (pick(w) !== want && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({15'h0, pick(w)}, {15'h0, want});
    if (pick(w) !== want)
      test_done;
  endtask
  // Long settle covers a temperature conversion
  task set_in(input logic st, input logic [11:0] x, input logic [11:0] y, input logic [9:0] t);
    @(posedge mclk);
    self_test_in <= st;
    accel_x_code <= x;
    accel_y_code <= y;
    temp_code <= t;
    repeat (400) @(posedge mclk);
  endtask
  initial begin
    sys_rst = 1'b1;
    self_test_in = 1'b0;
    accel_x_code = 12'h800;
    accel_y_code = 12'h800;
    temp_code = 10'h000;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({13'h0, dout_oe, shutdown, axis_is_y}, 16'h0000);
    foreach (rows[i]) begin
      set_in(rows[i].st, rows[i].x, rows[i].y, rows[i].t);
      host.frame(rows[i].acc, rows[i].word, rows[i].acc ? 2 : 1, rx);
      chk(rx, rows[i].exp);
      if (rows[i].acc)
        wait_sig(1, rows[i].word[3]);
      $display("row %0d done", i);
    end
    set_in(1'b0, 12'h800, 12'h000, 10'h000);
    host.frame(1'b1, 8'h0D, 1, rx);
    chk(rx, 16'h0800);
    wait_sig(0, 1'b1);
    set_in(1'b0, 12'h8AB, 12'h000, 10'h000);
    host.frame(1'b1, 8'h0D, 1, rx);
    chk(rx, 16'h0800);
    wait_sig(1, 1'b1);
    host.frame(1'b1, 8'h04, 1, rx);
    chk(rx, 16'h0800);
    wait_sig(0, 1'b0);
    set_in(1'b0, 12'h8AB, 12'h000, 10'h000);
    host.frame(1'b1, 8'h04, 1, rx);
    chk(rx, 16'h08AB);
    $display("power-down done");
    host.frame(1'b0, 8'h80, 1, rx);
    wait_sig(3, 1'b1);
    host.frame(1'b0, 8'h00, 1, rx);
    wait_sig(3, 1'b0);
    fork
      host.both_low();
      wait_sig(2, 1'b1);
    join
    chk({15'h0, dout_oe}, 16'h0000);
    $display("faults done");
    host.frame(1'b1, 8'h0C, 1, rx);
    wait_sig(1, 1'b1);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({13'h0, dout_oe, shutdown, axis_is_y}, 16'h0000);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({13'h0, dout_oe, shutdown, axis_is_y}, 16'h0000);
    $display("reset done");
    test_done;
  end
endmodule
